// File: logic/emcfg_axil.sv
module emcfg_axil
  import emcfg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_stb,
  output logic [11:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  logic aw_held_r;
  logic w_held_r;

  assign s_axi_awready = ce && !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = ce && !w_held_r && !s_axi_bvalid;
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign wr_stb = ce && aw_held_r && w_held_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      wr_addr <= 12'h000;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        wr_addr <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_stb) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OK : RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OK;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_ok ? rd_data : 32'h00000000;
        s_axi_rresp <= rd_ok ? RESP_OK : RESP_ERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : emcfg_axil

// File: logic/emcfg_pause_timer.sv
module emcfg_pause_timer
  import emcfg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic load,
  input wire logic [15:0] quanta,
  output logic active
);
  logic [15:0] left_r;
  logic [2:0] pre_r;

  assign active = left_r != 16'h0000;

  // restart on every new frame; zero quanta ends the pause
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_r <= 16'h0000;
      pre_r <= 3'h0;
    end else if (ce) begin
      if (load) begin
        left_r <= quanta;
        pre_r <= 3'h0;
      end else if (active) begin
        pre_r <= pre_r + 3'h1;
        if (pre_r == 3'(QUANTUM_CYC - 1)) begin
          left_r <= left_r - 16'h0001;
          pre_r <= 3'h0;
        end
      end
    end
  end
endmodule : emcfg_pause_timer

// File: logic/emcfg_pkg.sv
package emcfg_pkg;
  localparam logic [11:0] OFS_STA_LO = 12'h00C;
  localparam logic [11:0] OFS_STA_HI = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h040;
  localparam logic [11:0] OFS_GAP = 12'h044;
  localparam logic [11:0] OFS_CRCM = 12'h048;
  localparam logic [11:0] OFS_CRCINV = 12'h04C;
  localparam logic [11:0] OFS_TSTIME = 12'h07C;
  localparam logic [11:0] OFS_XIF = 12'h080;
  localparam logic [11:0] OFS_CMD = 12'h108;
  localparam logic [31:0] RST_GAP = 32'h0000000C;
  localparam logic [31:0] RST_CRCINV = 32'hFFFFFFFF;
  localparam logic [31:0] MSK_GAP = 32'hFFFF003F;
  localparam logic [31:0] MSK_CRCM = 32'h00010000;
  localparam logic [31:0] MSK_XIF = 32'h00001020;
  localparam logic [31:0] MSK_CMD = 32'h347FFF93;
  localparam logic [31:0] MSK_STA_HI = 32'h0000FFFF;
  localparam int B_SHORT = 0;
  localparam int B_CRC_OFF = 16;
  localparam int B_UPD64 = 12;
  localparam int B_ONESTEP = 5;
  localparam int B_TS_RDY = 3;
  localparam int B_RXP_DIS = 29;
  localparam int B_TXP_DIS = 28;
  localparam int B_FIFO_RST = 26;
  localparam int B_FLUSH = 22;
  localparam int B_COMPAT = 20;
  localparam int B_PFC = 19;
  localparam int B_MASK_E = 18;
  localparam int B_MASK_P = 17;
  localparam int B_CTRL_PASS = 13;
  localparam int B_SW_RST = 12;
  localparam int B_ADDR_INS = 9;
  localparam int B_P_IGNORE = 8;
  localparam int B_P_FWD = 7;
  localparam int B_PROMISC = 4;
  localparam int B_RX_ON = 1;
  localparam int B_TX_ON = 0;
  localparam logic [7:0] IPG_MIN = 8'h0C;
  localparam logic [7:0] GAP_ALIGN = 8'h04;
  localparam logic [7:0] SHORT_CUT = 8'h04;
  localparam logic [15:0] ETYPE_CTRL = 16'h8808;
  localparam logic [15:0] OP_LINK = 16'h0001;
  localparam logic [15:0] OP_PFC = 16'h0101;
  localparam int QUANTUM_BITS = 512;
  localparam int PATH_BITS = 64;
  localparam int QUANTUM_CYC = QUANTUM_BITS / PATH_BITS;
  localparam int CLK_PERIOD_NS = 8;
  localparam logic [63:0] FRC_STEP = 64'(CLK_PERIOD_NS);
  localparam logic [2:0] SC_SEQ_CYC = 3'h4;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
endpackage : emcfg_pkg

// File: logic/emcfg_top.sv
// Local design decision: the AXI4-Lite interface to the registers.
module emcfg_top
  import emcfg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic gap_req,
  output logic [7:0] gap_bytes,
  output logic gap_valid,
  input wire logic blk_tick,
  output logic idle_drop,
  output logic crc_check_off,
  input wire logic tx_crc_valid,
  input wire logic [31:0] tx_crc_in,
  input wire logic tx_crc_inv,
  output logic [31:0] tx_crc_out,
  output logic tx_crc_out_valid,
  input wire logic tx_ts_valid,
  input wire logic tx_ts_flag,
  input wire logic [31:0] tx_ts_value,
  input wire logic os_req,
  input wire logic os_wide,
  input wire logic [31:0] os_time_in,
  output logic [63:0] os_stamp,
  output logic os_stamp_valid,
  output logic low_latency_path,
  input wire logic rx_ctrl_valid,
  input wire logic [15:0] rx_ctrl_type,
  input wire logic [15:0] rx_ctrl_opcode,
  input wire logic [15:0] rx_ctrl_quanta,
  input wire logic [7:0] rx_ctrl_prio_en,
  output logic rx_ctrl_fwd,
  output logic rx_ctrl_drop,
  output logic tx_halt_express,
  output logic tx_halt_preempt,
  output logic rx_pause_status,
  output logic [7:0] pfc_status,
  input wire logic [7:0] xoff_gen,
  output logic [7:0] tx_xoff_req,
  output logic tx_xon_send,
  output logic tx_fifo_reset,
  output logic credit_reset,
  output logic datapath_reset,
  output logic tx_drain,
  output logic source_addr_overwrite,
  output logic [47:0] station_addr,
  output logic accept_all_frames,
  output logic rx_path_on,
  output logic tx_path_on
);
  logic wr_stb;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [31:0] rd_data;
  logic rd_ok;
  logic [31:0] gap_r, crcm_r, crcinv_r, ts_r, xif_r, cmd_r, sta_lo_r, sta_hi_r;
  logic tx_time_ready_r;
  logic [2:0] sc_cnt_r [2];
  logic [31:0] wmask;
  logic [8:0] tmr_load;
  logic [8:0] tmr_act;
  logic [63:0] frc_r;
  logic signed [4:0] credit_r;
  logic [15:0] blk_cnt_r;
  logic txp_dis_q_r;

  emcfg_axil u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  assign wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [31:0] m, input logic [31:0] rw);
    merge = (old & ~(m & rw)) | (d & m & rw);
  endfunction : merge

  always_comb begin
    wr_ok = 1'b1;
    unique case (wr_addr)
      OFS_STA_LO, OFS_STA_HI, OFS_STATUS, OFS_GAP, OFS_CRCM, OFS_CRCINV, OFS_TSTIME,
      OFS_XIF, OFS_CMD: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_comb begin
    rd_ok = 1'b1;
    rd_data = 32'h00000000;
    unique case ({s_axi_araddr[11:2], 2'b00})
      OFS_STA_LO: rd_data = sta_lo_r;
      OFS_STA_HI: rd_data = sta_hi_r;
      OFS_STATUS: rd_data = 32'(tx_time_ready_r) << B_TS_RDY;
      OFS_GAP: rd_data = gap_r;
      OFS_CRCM: rd_data = crcm_r;
      OFS_CRCINV: rd_data = crcinv_r;
      OFS_TSTIME: rd_data = ts_r;
      OFS_XIF: rd_data = xif_r;
      OFS_CMD: rd_data = cmd_r;
      default: rd_ok = 1'b0;
    endcase
  end

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_r <= RST_GAP;
      crcm_r <= 32'h00000000;
      crcinv_r <= RST_CRCINV;
      xif_r <= 32'h00000000;
      sta_lo_r <= 32'h00000000;
      sta_hi_r <= 32'h00000000;
    end else if (ce && wr_stb) begin
      if (wr_addr == OFS_GAP) gap_r <= merge(gap_r, wr_data, wmask, MSK_GAP);
      if (wr_addr == OFS_CRCM) crcm_r <= merge(crcm_r, wr_data, wmask, MSK_CRCM);
      if (wr_addr == OFS_CRCINV) crcinv_r <= merge(crcinv_r, wr_data, wmask, RST_CRCINV);
      if (wr_addr == OFS_XIF) xif_r <= merge(xif_r, wr_data, wmask, MSK_XIF);
      if (wr_addr == OFS_STA_LO) sta_lo_r <= merge(sta_lo_r, wr_data, wmask, RST_CRCINV);
      if (wr_addr == OFS_STA_HI) sta_hi_r <= merge(sta_hi_r, wr_data, wmask, MSK_STA_HI);
    end
  end

  // command register; the two self-clearing bits run a short sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_r <= 32'h00000000;
      sc_cnt_r[0] <= 3'h0;
      sc_cnt_r[1] <= 3'h0;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if (sc_cnt_r[i] != 3'h0) sc_cnt_r[i] <= sc_cnt_r[i] - 3'h1;
      end
      if (sc_cnt_r[0] == 3'h1) cmd_r[B_FIFO_RST] <= 1'b0;
      if (sc_cnt_r[1] == 3'h1) cmd_r[B_SW_RST] <= 1'b0;
      if (wr_stb && wr_addr == OFS_CMD) begin
        cmd_r <= merge(cmd_r, wr_data, wmask, MSK_CMD);
        if (wmask[B_FIFO_RST] && wr_data[B_FIFO_RST]) sc_cnt_r[0] <= SC_SEQ_CYC;
        if (wmask[B_SW_RST] && wr_data[B_SW_RST]) sc_cnt_r[1] <= SC_SEQ_CYC;
      end
    end
  end

  assign tx_fifo_reset = cmd_r[B_FIFO_RST];
  assign credit_reset = cmd_r[B_FIFO_RST];
  assign datapath_reset = cmd_r[B_SW_RST];
  assign tx_drain = cmd_r[B_FLUSH];
  assign source_addr_overwrite = cmd_r[B_ADDR_INS];
  assign station_addr = {sta_hi_r[15:0], sta_lo_r};
  assign accept_all_frames = cmd_r[B_PROMISC];
  assign rx_path_on = cmd_r[B_RX_ON];
  assign tx_path_on = cmd_r[B_TX_ON];
  assign crc_check_off = crcm_r[B_CRC_OFF];
  assign low_latency_path = !xif_r[B_ONESTEP];

  // deficit idle count on a 4-byte grid keeps each gap within 3 bytes of average, except in short mode (4 below)
  logic [7:0] gap_avg;
  logic [7:0] gap_want;
  logic [7:0] gap_pick;
  always_comb begin
    gap_avg = ({2'b00, gap_r[5:2], 2'b00} < IPG_MIN) ? IPG_MIN
                                                     : {2'b00, gap_r[5:2], 2'b00};
    gap_want = gap_avg + 8'(signed'({{3{credit_r[4]}}, credit_r}));
    gap_pick = (gap_want[1:0] >= 2'h2) ? ((gap_want & ~(GAP_ALIGN - 8'h01)) + GAP_ALIGN)
                                       : (gap_want & ~(GAP_ALIGN - 8'h01));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      credit_r <= 5'sh00;
      gap_bytes <= IPG_MIN;
      gap_valid <= 1'b0;
    end else if (ce) begin
      gap_valid <= gap_req;
      if (gap_req) begin
        if (gap_r[B_SHORT]) begin
          gap_bytes <= gap_avg - SHORT_CUT;
          credit_r <= 5'sh00;
        end else begin
          gap_bytes <= gap_pick;
          credit_r <= 5'(signed'(gap_want - gap_pick));
        end
      end
    end
  end

  // idle block removal for alignment marker compensation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blk_cnt_r <= 16'h0000;
      idle_drop <= 1'b0;
    end else if (ce) begin
      idle_drop <= 1'b0;
      if (gap_r[31:16] == 16'h0000) begin
        blk_cnt_r <= 16'h0000;
      end else if (blk_tick) begin
        if (blk_cnt_r >= gap_r[31:16] - 16'h0001) begin
          blk_cnt_r <= 16'h0000;
          idle_drop <= 1'b1;
        end else begin
          blk_cnt_r <= blk_cnt_r + 16'h0001;
        end
      end
    end
  end

  // transmit CRC invert
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_crc_out <= 32'h00000000;
      tx_crc_out_valid <= 1'b0;
    end else if (ce) begin
      tx_crc_out_valid <= tx_crc_valid;
      if (tx_crc_valid) tx_crc_out <= tx_crc_in ^ (tx_crc_inv ? crcinv_r : 32'h00000000);
    end
  end

  // transmit timestamp capture; a new capture beats a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ts_r <= 32'h00000000;
      tx_time_ready_r <= 1'b0;
    end else if (ce) begin
      if (tx_ts_valid && tx_ts_flag) begin
        ts_r <= tx_ts_value;
        tx_time_ready_r <= 1'b1;
      end else if (wr_stb && wr_addr == OFS_STATUS && wmask[B_TS_RDY] && wr_data[B_TS_RDY]) begin
        tx_time_ready_r <= 1'b0;
      end
    end
  end

  // free-running time and one-step stamping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frc_r <= 64'h0000000000000000;
      os_stamp <= 64'h0000000000000000;
      os_stamp_valid <= 1'b0;
    end else if (ce) begin
      frc_r <= frc_r + FRC_STEP;
      os_stamp_valid <= os_req && xif_r[B_ONESTEP];
      if (os_req && xif_r[B_ONESTEP]) begin
        os_stamp <= (os_wide && xif_r[B_UPD64]) ? {os_time_in, frc_r[31:0]} : frc_r;
      end
    end
  end

  // received control frame classification
  logic ctrl_hit;
  logic pause_hit;
  logic rxp_dis;
  logic pause_mask;
  assign ctrl_hit = rx_ctrl_valid && rx_ctrl_type == ETYPE_CTRL;
  assign pause_hit = ctrl_hit && rx_ctrl_opcode == (cmd_r[B_PFC] ? OP_PFC : OP_LINK);
  assign rxp_dis = cmd_r[B_RXP_DIS] || cmd_r[B_P_IGNORE];
  assign pause_mask = cmd_r[B_RXP_DIS] || cmd_r[B_FLUSH];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_ctrl_fwd <= 1'b0;
      rx_ctrl_drop <= 1'b0;
    end else if (ce) begin
      rx_ctrl_fwd <= ctrl_hit && (pause_hit ? cmd_r[B_P_FWD] : cmd_r[B_CTRL_PASS]);
      rx_ctrl_drop <= ctrl_hit && !(pause_hit ? cmd_r[B_P_FWD] : cmd_r[B_CTRL_PASS]);
    end
  end

  // timers 0..7 serve priorities, timer 8 serves link pause
  genvar g;
  generate
    for (g = 0; g < 9; g++) begin : g_tmr
      if (g < 8) begin : g_pfc
        assign tmr_load[g] = pause_hit && !rxp_dis && cmd_r[B_PFC] && rx_ctrl_prio_en[g];
      end else begin : g_link
        assign tmr_load[g] = pause_hit && !rxp_dis && !cmd_r[B_PFC];
      end
      emcfg_pause_timer u_tmr (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .load(tmr_load[g]),
        .quanta(rx_ctrl_quanta),
        .active(tmr_act[g])
      );
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_halt_express <= 1'b0;
      tx_halt_preempt <= 1'b0;
      rx_pause_status <= 1'b0;
      pfc_status <= 8'h00;
    end else if (ce) begin
      tx_halt_express <= tmr_act[8] && !pause_mask && !cmd_r[B_PFC] && !cmd_r[B_COMPAT]
                         && !cmd_r[B_MASK_E];
      tx_halt_preempt <= tmr_act[8] && !pause_mask && !cmd_r[B_PFC] && !cmd_r[B_COMPAT]
                         && !cmd_r[B_MASK_P];
      rx_pause_status <= tmr_act[8] && !pause_mask && !cmd_r[B_PFC];
      pfc_status <= tmr_act[7:0] & {8{!pause_mask && cmd_r[B_PFC]}};
    end
  end

  // transmit pause generation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_xoff_req <= 8'h00;
      tx_xon_send <= 1'b0;
      txp_dis_q_r <= 1'b0;
    end else if (ce) begin
      txp_dis_q_r <= cmd_r[B_TXP_DIS];
      tx_xoff_req <= xoff_gen & {8{!cmd_r[B_TXP_DIS] && !cmd_r[B_FLUSH]}};
      tx_xon_send <= cmd_r[B_TXP_DIS] && !txp_dis_q_r && (tx_xoff_req != 8'h00);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_fifo_rst_start;
    ce && wr_stb && wr_addr == OFS_CMD && wmask[B_FIFO_RST] && wr_data[B_FIFO_RST];
  endsequence
  sequence s_fifo_rst_run;
    tx_fifo_reset && credit_reset;
  endsequence

  a_crc_invert_apply: assert property (ce && tx_crc_valid |=>
    tx_crc_out == ($past(tx_crc_in) ^ ($past(tx_crc_inv) ? $past(crcinv_r) : 32'h00000000)))
    else $error("crc invert mask misapplied");
  a_ts_capture_val: assert property (ce && tx_ts_valid && tx_ts_flag |=>
    ts_r == $past(tx_ts_value) && tx_time_ready_r)
    else $error("timestamp not captured");
  a_gap_within_dic: assert property (gap_valid && !gap_r[B_SHORT] |->
    gap_bytes + 8'h03 >= gap_avg && gap_bytes <= gap_avg + 8'h03)
    else $error("gap outside deficit bounds");
  a_fifo_rst_clears: assert property (s_fifo_rst_start ##1 ce[*4] |->
    s_fifo_rst_run ##[1:4] !tx_fifo_reset)
    else $error("fifo reset did not self clear");
  a_rxdis_no_halt: assert property (cmd_r[B_RXP_DIS] [*2] |->
    !tx_halt_express && !tx_halt_preempt && pfc_status == 8'h00)
    else $error("pause acted while disabled");
  a_onestep_ignore: assert property (ce && os_req && !xif_r[B_ONESTEP] |=> !os_stamp_valid)
    else $error("one-step request not ignored");
  a_wide_stamp: assert property (
    ce && os_req && os_wide && xif_r[B_ONESTEP] && xif_r[B_UPD64] |=>
    os_stamp[63:32] == $past(os_time_in))
    else $error("wide stamp high word wrong");
  a_ctrl_forward: assert property (
    ce && ctrl_hit && !pause_hit && cmd_r[B_CTRL_PASS] |=> rx_ctrl_fwd && !rx_ctrl_drop)
    else $error("control frame not forwarded");
  a_xon_on_disable: assert property (
    ce && $rose(cmd_r[B_TXP_DIS]) && tx_xoff_req != 8'h00 |=> tx_xon_send)
    else $error("resume frame not sent");
  a_flush_masks: assert property (
    cmd_r[B_FLUSH] [*2] |-> !rx_pause_status && tx_xoff_req == 8'h00)
    else $error("pause not masked during flush");
endmodule : emcfg_top

// File: tb/emcfg_app.sv
module emcfg_app (
  input wire logic aclk,
  input wire logic go,
  input wire logic [31:0] val,
  input wire logic inv,
  output logic tx_crc_valid = 1'h0,
  output logic [31:0] tx_crc_in = 32'h0,
  output logic tx_crc_inv = 1'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  // data line is not held between frames
  always @(posedge aclk) begin
    tx_crc_valid <= go;
    tx_crc_inv <= go & inv;
    tx_crc_in <= go ? val : ~tx_crc_in;
  end
endmodule : emcfg_app

// File: tb/tb_top.sv
module tb_top;
  import emcfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = '0, aresetn = '0, ce = 1'h1, s_axi_awvalid = '0, s_axi_wvalid = '0;
  logic s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, gap_req = '0;
  logic blk_tick = '0, gap_valid, idle_drop, tx_crc_valid, tx_crc_inv, tx_crc_out_valid;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, tx_crc_in, tx_crc_out, tx_ts_value = '0;
  logic [31:0] os_time_in = '0, val = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0] gap_bytes, rx_ctrl_prio_en = '0, pfc_status, xoff_gen = '0, tx_xoff_req;
  logic tx_ts_valid = '0, tx_ts_flag = '0, os_req = '0, os_wide = '0, os_stamp_valid;
  logic low_latency_path, crc_check_off, rx_ctrl_valid = '0, rx_ctrl_fwd, rx_ctrl_drop;
  logic [63:0] os_stamp;
  logic [47:0] station_addr;
  logic [15:0] rx_ctrl_type = '0, rx_ctrl_opcode = '0, rx_ctrl_quanta = '0;
  logic tx_halt_express, tx_halt_preempt, rx_pause_status, tx_xon_send, tx_fifo_reset;
  logic credit_reset, datapath_reset, tx_drain, source_addr_overwrite, accept_all_frames;
  logic rx_path_on, tx_path_on, go = '0, inv = '0;
  int bad_count = 0, total_checks = 0;
  emcfg_top i_dut (.*);
  emcfg_app i_app (.aclk(aclk), .go(go), .val(val), .inv(inv), .tx_crc_valid(tx_crc_valid),
    .tx_crc_in(tx_crc_in), .tx_crc_inv(tx_crc_inv));
  initial forever #4 aclk = ~aclk;
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    rsp = s_axi_bresp;
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string s);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    rsp = s_axi_rresp;
    chk(s, e, s_axi_rdata);
  endtask : rdc
  task automatic crc(input logic [31:0] v, input logic i, input logic [31:0] e);
    @(posedge aclk);
    go <= 1'h1;
    val <= v;
    inv <= i;
    @(posedge aclk);
    go <= 1'h0;
    @(posedge aclk);
    #1 chk("crc", e, tx_crc_out);
    chk("crcv", 32'h1, {31'h0, tx_crc_out_valid});
  endtask : crc
  task automatic scc(input logic [31:0] c, input string s);
    logic [31:0] k;
    k = 32'h0;
    fork
      wr(OFS_CMD, c);
      repeat (14) @(posedge aclk) k = k + {31'h0,
        (c[B_SW_RST] ? datapath_reset : (tx_fifo_reset & credit_reset))};
    join
    chk(s, 32'(SC_SEQ_CYC), k);
  endtask : scc
  task automatic idlec;
    logic [31:0] k;
    k = 32'h0;
    wr(OFS_GAP, 32'h0003000C);
    blk_tick <= 1'h1;
    repeat (6) @(posedge aclk) k = k + {31'h0, idle_drop};
    blk_tick <= 1'h0;
    repeat (2) @(posedge aclk) k = k + {31'h0, idle_drop};
    chk("idle", 32'h2, k);
  endtask : idlec
  task automatic gapc(input logic [31:0] v, input logic [7:0] e);
    wr(OFS_GAP, v);
    gap_req <= 1'h1;
    @(posedge aclk);
    gap_req <= 1'h0;
    #1 chk("gap", {24'h0, e}, {24'h0, gap_bytes});
    chk("gapv", 32'h1, {31'h0, gap_valid});
  endtask : gapc
  task automatic osc(input logic w, input logic v, input logic [31:0] e);
    @(posedge aclk);
    os_req <= 1'h1;
    os_wide <= w;
    os_time_in <= 32'h89ABCDEF;
    @(posedge aclk);
    os_req <= 1'h0;
    #1 chk("osv", {31'h0, v}, {31'h0, os_stamp_valid});
    chk("oshi", e, os_stamp[63:32]);
  endtask : osc
  // counts per cycle: express halt, preemptable halt, pause status, priority status
  task automatic pz(input logic [31:0] c, input logic [15:0] op, input logic f,
                    input logic [31:0] e);
    logic [31:0] k;
    k = 32'h0;
    wr(OFS_CMD, c);
    @(posedge aclk);
    rx_ctrl_valid <= 1'h1;
    rx_ctrl_type <= ETYPE_CTRL;
    rx_ctrl_opcode <= op;
    rx_ctrl_quanta <= 16'h0002;
    rx_ctrl_prio_en <= 8'h05;
    @(posedge aclk);
    rx_ctrl_valid <= 1'h0;
    #1 chk("fwd", {31'h0, f}, {31'h0, rx_ctrl_fwd});
    chk("drop", {31'h0, ~f}, {31'h0, rx_ctrl_drop});
    repeat (20) @(posedge aclk) k = k + {7'h0, tx_halt_express, 7'h0, tx_halt_preempt,
      7'h0, rx_pause_status, pfc_status};
    chk("pause", e, k);
  endtask : pz
  task automatic xonc;
    logic [31:0] k;
    k = 32'h0;
    @(posedge aclk);
    xoff_gen <= 8'h03;
    repeat (2) @(posedge aclk);
    #1 chk("xoff", 32'h3, {24'h0, tx_xoff_req});
    fork
      wr(OFS_CMD, 32'h10000000);
      repeat (10) @(posedge aclk) k = k + {31'h0, tx_xon_send};
    join
    chk("xon", 32'h1, k);
    chk("xoffdis", 32'h0, {24'h0, tx_xoff_req});
    xoff_gen <= 8'h00;
  endtask : xonc
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    rdc(OFS_GAP, RST_GAP, "gap");
    rdc(OFS_CRCINV, RST_CRCINV, "mask");
    rdc(OFS_CMD, 32'h0, "cmd");
    chk("lowlat", 32'h1, {31'h0, low_latency_path});
    wr(OFS_GAP, 32'hFFFFFFFF);
    rdc(OFS_GAP, MSK_GAP, "gapmask");
    wr(12'h000, 32'h1);
    chk("bresp", {30'h0, RESP_ERR}, {30'h0, rsp});
    rdc(12'h004, 32'h0, "unmapped");
    chk("rresp", {30'h0, RESP_ERR}, {30'h0, rsp});
    $display("test regs done");
    wr(OFS_CRCM, 32'hFFFFFFFF);
    rdc(OFS_CRCM, MSK_CRCM, "crcm");
    chk("chkoff", 32'h1, {31'h0, crc_check_off});
    wr(OFS_CRCINV, 32'h0F0F00F0);
    crc(32'h12345678, 1'h1, 32'h12345678 ^ 32'h0F0F00F0);
    crc(32'hA5A5A5A5, 1'h0, 32'hA5A5A5A5);
    $display("test crc done");
    @(posedge aclk);
    tx_ts_valid <= 1'h1;
    tx_ts_flag <= 1'h1;
    tx_ts_value <= 32'hCAFE0123;
    @(posedge aclk);
    tx_ts_flag <= 1'h0;
    tx_ts_value <= 32'h11110000;
    @(posedge aclk);
    tx_ts_valid <= 1'h0;
    rdc(OFS_TSTIME, 32'hCAFE0123, "tstime");
    rdc(OFS_STATUS, 32'h8, "tsrdy");
    wr(OFS_STATUS, 32'h8);
    rdc(OFS_STATUS, 32'h0, "tsclr");
    $display("test stamp done");
    scc(32'h04000000, "fiforst");
    rdc(OFS_CMD, 32'h0, "scclr");
    scc(32'h00001000, "swrst");
    wr(OFS_CMD, 32'h00000213);
    rdc(OFS_CMD, 32'h00000213, "cmdrw");
    chk("outs", 32'hF, {28'h0, source_addr_overwrite, accept_all_frames, rx_path_on,
      tx_path_on});
    wr(OFS_STA_LO, 32'h89ABCDEF);
    wr(OFS_STA_HI, 32'hFFFF4567);
    rdc(OFS_STA_HI, 32'h00004567, "stareg");
    chk("stalo", 32'h89ABCDEF, station_addr[31:0]);
    chk("stahi", 32'h00004567, {16'h0, station_addr[47:32]});
    $display("test command done");
    idlec();
    gapc(32'h00000014, 8'h14);
    gapc(32'h00000015, 8'h10);
    gapc(32'h00000004, IPG_MIN);
    $display("test gap done");
    osc(1'h1, 1'h0, 32'h0);
    wr(OFS_XIF, 32'h00001020);
    chk("lowlat2", 32'h0, {31'h0, low_latency_path});
    osc(1'h1, 1'h1, 32'h89ABCDEF);
    osc(1'h0, 1'h1, 32'h0);
    $display("test one-step done");
    pz(32'h0, OP_LINK, 1'h0, 32'h10101000);
    pz(32'h00040000, OP_LINK, 1'h0, 32'h00101000);
    pz(32'h00100000, OP_LINK, 1'h0, 32'h00001000);
    pz(32'h00080000, OP_PFC, 1'h0, 32'h00000050);
    pz(32'h20080000, OP_PFC, 1'h0, 32'h0);
    pz(32'h00000180, OP_LINK, 1'h1, 32'h0);
    pz(32'h00002000, 16'h0002, 1'h1, 32'h0);
    pz(32'h0, 16'h0002, 1'h0, 32'h0);
    xonc();
    pz(32'h00400000, OP_LINK, 1'h0, 32'h0);
    chk("drain", 32'h1, {31'h0, tx_drain});
    $display("test pause done");
    final_report();
  end
endmodule : tb_top
